// File: hdl/vw_pkg.sv
// shared constants and helpers for the variable-width select-framed link
// assumes both ends import nothing and reference vw_pkg::name
//
// Contract
// - data bus runs 1, 2, 4 or 8 lanes
// - idle: lane 0 write status, miso read status
// - option switches idle status drive off
// - frame is command phase, then data phases
// - slave answers each byte with ack/nak
// - master may burst; aborts on nak
// - width sampled at first edge, command at last command edge
// - width decoded by lane priority
// - undriven lanes pulled up, read as one
// - four command bits from non-width positions
// - fixed command byte bit layout
// - slave releases lane 0 on select
// - 1-lane command 7 clocks, 8th turnaround
// - 1-lane data phase is 8 clocks
// - ack/nak held over whole data phase
// - writing master releases lanes before deselect
// - after read, slave drives status directly
package vw_pkg;

	localparam int LANES = 8;

	// width codes: lane count is 1 << code
	localparam logic [1:0] W1 = 2'h0;
	localparam logic [1:0] W2 = 2'h1;
	localparam logic [1:0] W4 = 2'h2;
	localparam logic [1:0] W8 = 2'h3;

	// command byte bit positions
	localparam int CB_CMD3 = 0;
	localparam int CB_W2 = 1;
	localparam int CB_W4 = 2;
	localparam int CB_CMD2 = 3;
	localparam int CB_W8 = 4;
	localparam int CB_CMD1 = 5;
	localparam int CB_CMD0 = 6;

	localparam logic [3:0] CMD_WRITE = 4'h0;
	localparam logic [3:0] CMD_READ = 4'h1;
	localparam logic ACK_LVL = 1'h1;

	// controller register map and fields
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_W_LSB = 4;
	localparam int CTRL_WDATA_LSB = 8;
	localparam int CTRL_GO = 31;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NAK = 1;
	localparam int STAT_WRF = 2;
	localparam int STAT_RDA = 3;
	localparam int STAT_RDATA_LSB = 8;

	function automatic logic [1:0] decode_width(input logic [7:0] l);
		logic [1:0] r;
		if (!(&l[7:4])) r = W8;
		else if (!(&l[3:2])) r = W4;
		else if (!l[1]) r = W2;
		else r = W1;
		return r;
	endfunction

	function automatic logic [3:0] cmd_of(input logic [7:0] b);
		return {b[CB_CMD3], b[CB_CMD2], b[CB_CMD1], b[CB_CMD0]};
	endfunction

	function automatic logic [7:0] cmd_byte(input logic [3:0] c, input logic [1:0] w);
		logic [7:0] b;
		b = 8'hFF;
		b[CB_CMD3] = c[3];
		b[CB_CMD2] = c[2];
		b[CB_CMD1] = c[1];
		b[CB_CMD0] = c[0];
		b[CB_W2] = (w != W2);
		b[CB_W4] = (w != W4);
		b[CB_W8] = (w != W8);
		return b;
	endfunction

	function automatic logic [3:0] beats(input logic [1:0] w);
		return 4'h8 >> w;
	endfunction

	function automatic logic [7:0] mask(input logic [1:0] w);
		logic [7:0] m;
		case (w)
			W1: m = 8'h01;
			W2: m = 8'h03;
			W4: m = 8'h0F;
			default: m = 8'hFF;
		endcase
		return m;
	endfunction

	// lsb-first: new chunk enters at the top
	function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [7:0] l,
			input logic [1:0] w);
		logic [7:0] r;
		case (w)
			W1: r = {l[0], s[7:1]};
			W2: r = {l[1:0], s[7:2]};
			W4: r = {l[3:0], s[7:4]};
			default: r = l;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] shift_out(input logic [7:0] s, input logic [1:0] w);
		logic [7:0] r;
		case (w)
			W1: r = {1'h0, s[7:1]};
			W2: r = {2'h0, s[7:2]};
			W4: r = {4'h0, s[7:4]};
			default: r = 8'h00;
		endcase
		return r;
	endfunction

endpackage

// File: hdl/vw_link_if.sv
// link wires between controller end and device end
// assumes pull-ups on every lane and on miso; wire levels resolved here
`timescale 1ns/1ns
interface vw_link_if;
	logic ss_n;
	logic sclk;
	logic [7:0] m_lane_o;
	logic [7:0] m_lane_oe;
	logic [7:0] s_lane_o;
	logic [7:0] s_lane_oe;
	logic s_miso_o;
	logic s_miso_oe;
	logic [7:0] bidir_data_lanes;
	logic miso;

	// device wins on contention so a fault is visible as wrong data
	assign bidir_data_lanes = (s_lane_oe & s_lane_o) | (~s_lane_oe & m_lane_oe & m_lane_o)
		| (~s_lane_oe & ~m_lane_oe);
	assign miso = s_miso_oe ? s_miso_o : 1'h1;

	modport dev (input ss_n, input sclk, input bidir_data_lanes,
		output s_lane_o, output s_lane_oe, output s_miso_o, output s_miso_oe);
	modport ctl (output ss_n, output sclk, output m_lane_o, output m_lane_oe,
		input bidir_data_lanes, input miso);
endinterface

// File: hdl/vw_dev_end.sv
// device end: link logic on the master's link clock, user side on i_clk
// assumes select and lanes are launched by the master on the link clock
`timescale 1ns/1ns
module vw_dev_end (
	vw_link_if.dev lk,
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_status_en,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	input wire logic i_rx_ready
);

	typedef enum logic {VW_CMD, VW_DATA} vw_lst_e;

	// user domain
	logic tx_tgl_ff;
	logic nxt_tx_tgl;
	logic [7:0] tx_data_ff;
	logic [7:0] nxt_tx_data;
	logic rx_ack_ff;
	logic nxt_rx_ack;
	logic txa_s1_ff;
	logic txa_s2_ff;
	logic rxt_s1_ff;
	logic rxt_s2_ff;

	// link domain, kept across frames
	logic tx_ack_ff;
	logic nxt_tx_ack;
	logic rx_tgl_ff;
	logic nxt_rx_tgl;
	logic [7:0] rx_byte_ff;
	logic [7:0] nxt_rx_byte;
	logic txt_l1_ff;
	logic txt_l2_ff;
	logic rxa_l1_ff;
	logic rxa_l2_ff;

	// link domain, cleared by deselect
	vw_lst_e st_ff;
	vw_lst_e nxt_st;
	logic first_ff;
	logic nxt_first;
	logic [1:0] wc_ff;
	logic [1:0] nxt_wc;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [7:0] sh_ff;
	logic [7:0] nxt_sh;
	logic [7:0] out_ff;
	logic [7:0] nxt_out;
	logic [3:0] cmd_ff;
	logic [3:0] nxt_cmd;
	logic ack_ff;
	logic nxt_ack;
	logic drv_ff;
	logic nxt_drv;

	logic idle_wr_free;
	logic idle_rd_avail;

	////////////////////////////////////////////////////////////////////////////
	// user side: one-byte holding registers crossed by toggles

	assign o_tx_ready = (tx_tgl_ff == txa_s2_ff);
	assign o_rx_valid = (rxt_s2_ff != rx_ack_ff);
	// stable while valid: link side will not overwrite before the ack returns
	assign o_rx_data = rx_byte_ff;

	always_comb begin
		nxt_tx_tgl = tx_tgl_ff;
		nxt_tx_data = tx_data_ff;
		nxt_rx_ack = rx_ack_ff;
		if (i_tx_valid && o_tx_ready) begin
			nxt_tx_tgl = !tx_tgl_ff;
			nxt_tx_data = i_tx_data;
		end
		if (o_rx_valid && i_rx_ready) begin
			nxt_rx_ack = !rx_ack_ff;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			tx_tgl_ff <= 1'h0;
			tx_data_ff <= 8'h00;
			rx_ack_ff <= 1'h0;
			txa_s1_ff <= 1'h0;
			txa_s2_ff <= 1'h0;
			rxt_s1_ff <= 1'h0;
			rxt_s2_ff <= 1'h0;
		end else begin
			tx_tgl_ff <= nxt_tx_tgl;
			tx_data_ff <= nxt_tx_data;
			rx_ack_ff <= nxt_rx_ack;
			txa_s1_ff <= tx_ack_ff;
			txa_s2_ff <= txa_s1_ff;
			rxt_s1_ff <= rx_tgl_ff;
			rxt_s2_ff <= rxt_s1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drive

	assign idle_wr_free = !o_rx_valid;
	assign idle_rd_avail = !o_tx_ready;

	always_comb begin
		lk.s_lane_o = 8'h00;
		lk.s_lane_oe = 8'h00;
		lk.s_miso_o = 1'h0;
		lk.s_miso_oe = 1'h0;
		if (lk.ss_n) begin
			// off when the lines are shared with other slaves
			if (i_status_en) begin
				lk.s_lane_o[0] = idle_wr_free;
				lk.s_lane_oe[0] = 1'h1;
				lk.s_miso_o = idle_rd_avail;
				lk.s_miso_oe = 1'h1;
			end
		end else begin
			// lanes released the instant select falls unless read data is due
			lk.s_miso_o = ack_ff;
			lk.s_miso_oe = 1'h1;
			if (drv_ff) begin
				lk.s_lane_o = out_ff & vw_pkg::mask(wc_ff);
				lk.s_lane_oe = vw_pkg::mask(wc_ff);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// link side frame engine

	always_comb begin
		logic [1:0] w;
		logic [7:0] s;
		logic [3:0] c;
		logic fin;
		w = first_ff ? vw_pkg::decode_width(lk.bidir_data_lanes) : wc_ff;
		s = vw_pkg::shift_in(sh_ff, lk.bidir_data_lanes, w);
		c = cmd_ff;
		fin = (cnt_ff == vw_pkg::beats(w) - 4'h1);
		nxt_st = st_ff;
		nxt_first = 1'h0;
		nxt_wc = w;
		nxt_sh = s;
		nxt_cnt = cnt_ff + 4'h1;
		nxt_out = drv_ff ? vw_pkg::shift_out(out_ff, w) : out_ff;
		nxt_cmd = cmd_ff;
		nxt_ack = ack_ff;
		nxt_drv = drv_ff;
		nxt_tx_ack = tx_ack_ff;
		nxt_rx_tgl = rx_tgl_ff;
		nxt_rx_byte = rx_byte_ff;
		if (fin) begin
			nxt_cnt = 4'h0;
			case (st_ff)
				VW_CMD: begin
					// last command slot doubles as the turnaround
					c = vw_pkg::cmd_of(s);
					nxt_cmd = c;
					nxt_st = VW_DATA;
				end
				default: begin
					if (c == vw_pkg::CMD_WRITE && ack_ff == vw_pkg::ACK_LVL) begin
						nxt_rx_byte = s;
						nxt_rx_tgl = !rx_tgl_ff;
					end
				end
			endcase
			// decide the answer for the coming data phase
			nxt_ack = !vw_pkg::ACK_LVL;
			nxt_drv = 1'h0;
			if (c == vw_pkg::CMD_READ && txt_l2_ff != tx_ack_ff) begin
				nxt_ack = vw_pkg::ACK_LVL;
				nxt_drv = 1'h1;
				nxt_out = tx_data_ff;
				nxt_tx_ack = !tx_ack_ff;
			end else if (c == vw_pkg::CMD_WRITE && rxa_l2_ff == nxt_rx_tgl) begin
				nxt_ack = vw_pkg::ACK_LVL;
			end
		end
	end

	// deselect ends the frame; the link clock may be stopped by then
	always_ff @(posedge lk.sclk or posedge lk.ss_n) begin
		if (lk.ss_n) begin
			st_ff <= VW_CMD;
			first_ff <= 1'h1;
			wc_ff <= vw_pkg::W1;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			out_ff <= 8'h00;
			cmd_ff <= 4'h0;
			ack_ff <= !vw_pkg::ACK_LVL;
			drv_ff <= 1'h0;
		end else begin
			st_ff <= nxt_st;
			first_ff <= nxt_first;
			wc_ff <= nxt_wc;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			out_ff <= nxt_out;
			cmd_ff <= nxt_cmd;
			ack_ff <= nxt_ack;
			drv_ff <= nxt_drv;
		end
	end

	// stale synchronisers at a frame start only ever report less room
	always_ff @(posedge lk.sclk or posedge i_rst) begin
		if (i_rst) begin
			tx_ack_ff <= 1'h0;
			rx_tgl_ff <= 1'h0;
			rx_byte_ff <= 8'h00;
			txt_l1_ff <= 1'h0;
			txt_l2_ff <= 1'h0;
			rxa_l1_ff <= 1'h0;
			rxa_l2_ff <= 1'h0;
		end else begin
			tx_ack_ff <= nxt_tx_ack;
			rx_tgl_ff <= nxt_rx_tgl;
			rx_byte_ff <= nxt_rx_byte;
			txt_l1_ff <= tx_tgl_ff;
			txt_l2_ff <= txt_l1_ff;
			rxa_l1_ff <= rx_ack_ff;
			rxa_l2_ff <= rxa_l1_ff;
		end
	end

endmodule

// File: hdl/vw_ctl_end.sv
// controller end: apb registers, link clock divider, one-byte frames
// assumes the device end runs on the link clock driven from here
`timescale 1ns/1ns
module vw_ctl_end #(
	parameter int unsigned DIV = 2
) (
	vw_link_if.ctl lk,
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);

	typedef enum logic [1:0] {M_IDLE, M_SEL, M_RUN, M_END} vw_mst_e;

	vw_mst_e st_ff;
	vw_mst_e nxt_st;
	logic [7:0] hc_ff;
	logic [7:0] nxt_hc;
	logic sclk_ff;
	logic nxt_sclk;
	logic ssn_ff;
	logic nxt_ssn;
	logic [4:0] edge_ff;
	logic [4:0] nxt_edge;
	logic [3:0] cmd_ff;
	logic [3:0] nxt_cmd;
	logic [1:0] wc_ff;
	logic [1:0] nxt_wc;
	logic [7:0] wdata_ff;
	logic [7:0] nxt_wdata;
	logic [7:0] sh_ff;
	logic [7:0] nxt_sh;
	logic [7:0] rd_ff;
	logic [7:0] nxt_rd;
	logic nak_ff;
	logic nxt_nak;
	logic [7:0] lo_ff;
	logic [7:0] nxt_lo;
	logic [7:0] loe_ff;
	logic [7:0] nxt_loe;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic wf_s1_ff;
	logic wf_s2_ff;
	logic ra_s1_ff;
	logic ra_s2_ff;

	localparam logic [7:0] HALF = 8'(DIV - 1);

	assign lk.ss_n = ssn_ff;
	assign lk.sclk = sclk_ff;
	assign lk.m_lane_o = lo_ff;
	assign lk.m_lane_oe = loe_ff;
	assign o_prdata = prdata_ff;
	assign o_pready = 1'h1;
	assign o_pslverr = i_psel && i_penable && i_paddr != vw_pkg::REG_CTRL
		&& i_paddr != vw_pkg::REG_STAT;

	always_comb begin
		logic [4:0] nb;
		logic [4:0] e;
		logic [7:0] b;
		nb = {1'h0, vw_pkg::beats(wc_ff)};
		e = edge_ff + 5'h01;
		b = vw_pkg::cmd_byte(cmd_ff, wc_ff);
		nxt_st = st_ff;
		nxt_hc = hc_ff;
		nxt_sclk = sclk_ff;
		nxt_ssn = ssn_ff;
		nxt_edge = edge_ff;
		nxt_cmd = cmd_ff;
		nxt_wc = wc_ff;
		nxt_wdata = wdata_ff;
		nxt_sh = sh_ff;
		nxt_rd = rd_ff;
		nxt_nak = nak_ff;
		nxt_lo = lo_ff;
		nxt_loe = loe_ff;
		nxt_prdata = prdata_ff;
		if (i_psel && !i_penable) begin
			nxt_prdata = 32'h0000_0000;
			if (i_paddr == vw_pkg::REG_STAT) begin
				nxt_prdata[vw_pkg::STAT_BUSY] = (st_ff != M_IDLE);
				nxt_prdata[vw_pkg::STAT_NAK] = nak_ff;
				nxt_prdata[vw_pkg::STAT_WRF] = wf_s2_ff;
				nxt_prdata[vw_pkg::STAT_RDA] = ra_s2_ff;
				nxt_prdata[vw_pkg::STAT_RDATA_LSB +: 8] = rd_ff;
			end
		end
		case (st_ff)
			M_IDLE: begin
				if (i_psel && i_penable && i_pwrite && i_paddr == vw_pkg::REG_CTRL) begin
					nxt_cmd = i_pwdata[vw_pkg::CTRL_CMD_LSB +: 4];
					nxt_wc = i_pwdata[vw_pkg::CTRL_W_LSB +: 2];
					nxt_wdata = i_pwdata[vw_pkg::CTRL_WDATA_LSB +: 8];
					if (i_pwdata[vw_pkg::CTRL_GO]) begin
						nxt_st = M_SEL;
						nxt_ssn = 1'h0;
						nxt_hc = HALF;
						nxt_edge = 5'h00;
						nxt_nak = 1'h0;
						nxt_rd = 8'h00;
					end
				end
			end
			M_SEL: begin
				nxt_hc = hc_ff - 8'h01;
				if (hc_ff == 8'h00) begin
					// lanes driven half a period after select, before the first edge
					nxt_lo = b & vw_pkg::mask(wc_ff);
					nxt_loe = vw_pkg::mask(wc_ff);
					nxt_sh = vw_pkg::shift_out(b, wc_ff);
					nxt_hc = HALF;
					nxt_st = M_RUN;
				end
			end
			M_RUN: begin
				nxt_hc = hc_ff - 8'h01;
				if (hc_ff == 8'h00) begin
					nxt_hc = HALF;
					nxt_sclk = !sclk_ff;
					if (!sclk_ff) begin
						nxt_edge = e;
						if (e == nb + 5'h01 && lk.miso != vw_pkg::ACK_LVL) begin
							nxt_nak = 1'h1;
						end
						if (e > nb) begin
							nxt_rd = vw_pkg::shift_in(rd_ff, lk.bidir_data_lanes, wc_ff);
						end
						// lanes never change at a rising link edge: the device samples there
						if (e == nb + nb || (e == nb + 5'h01 && lk.miso != vw_pkg::ACK_LVL)) begin
							nxt_st = M_END;
						end
					end else if (edge_ff < nb) begin
						nxt_lo = sh_ff & vw_pkg::mask(wc_ff);
						nxt_sh = vw_pkg::shift_out(sh_ff, wc_ff);
					end else if (cmd_ff == vw_pkg::CMD_WRITE) begin
						if (edge_ff == nb) begin
							nxt_lo = wdata_ff & vw_pkg::mask(wc_ff);
							nxt_sh = vw_pkg::shift_out(wdata_ff, wc_ff);
						end else begin
							nxt_lo = sh_ff & vw_pkg::mask(wc_ff);
							nxt_sh = vw_pkg::shift_out(sh_ff, wc_ff);
						end
					end
				end
				// turnaround one i_clk after edge n, once the last slot is sampled
				if (sclk_ff && edge_ff == nb && cmd_ff == vw_pkg::CMD_READ) begin
					nxt_loe = 8'h00;
				end
			end
			default: begin
				nxt_hc = hc_ff - 8'h01;
				// released after the last rising edge, ahead of deselect
				nxt_loe = 8'h00;
				if (hc_ff == 8'h00) begin
					nxt_sclk = 1'h0;
					nxt_ssn = 1'h1;
					nxt_st = M_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_ff <= M_IDLE;
			hc_ff <= 8'h00;
			sclk_ff <= 1'h0;
			ssn_ff <= 1'h1;
			edge_ff <= 5'h00;
			cmd_ff <= 4'h0;
			wc_ff <= vw_pkg::W1;
			wdata_ff <= 8'h00;
			sh_ff <= 8'h00;
			rd_ff <= 8'h00;
			nak_ff <= 1'h0;
			lo_ff <= 8'h00;
			loe_ff <= 8'h00;
			prdata_ff <= 32'h0000_0000;
			wf_s1_ff <= 1'h0;
			wf_s2_ff <= 1'h0;
			ra_s1_ff <= 1'h0;
			ra_s2_ff <= 1'h0;
		end else begin
			st_ff <= nxt_st;
			hc_ff <= nxt_hc;
			sclk_ff <= nxt_sclk;
			ssn_ff <= nxt_ssn;
			edge_ff <= nxt_edge;
			cmd_ff <= nxt_cmd;
			wc_ff <= nxt_wc;
			wdata_ff <= nxt_wdata;
			sh_ff <= nxt_sh;
			rd_ff <= nxt_rd;
			nak_ff <= nxt_nak;
			lo_ff <= nxt_lo;
			loe_ff <= nxt_loe;
			prdata_ff <= nxt_prdata;
			wf_s1_ff <= lk.bidir_data_lanes[0];
			wf_s2_ff <= wf_s1_ff;
			ra_s1_ff <= lk.miso;
			ra_s2_ff <= ra_s1_ff;
		end
	end

endmodule

// File: tb/vw_link_checker.sv
// concurrent checks on the link wires between the two ends
// assumes instantiation beside the link interface in the bench top
`timescale 1ns/1ns
module vw_link_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_status_en,
	input wire logic ss_n,
	input wire logic sclk,
	input wire logic [7:0] s_lane_oe,
	input wire logic s_miso_o,
	input wire logic s_miso_oe,
	input wire logic [7:0] bidir_data_lanes
);
	logic [4:0] cnt_ff;
	logic [3:0] n_ff;
	logic [7:0] cmd_ff;
	logic [3:0] n_dec;
	logic [7:0] lmask;

	// edges per byte from the first-edge lane levels
	assign n_dec = !(&bidir_data_lanes[7:4]) ? 4'h1 : !(&bidir_data_lanes[3:2]) ? 4'h2
		: !bidir_data_lanes[1] ? 4'h4 : 4'h8;
	assign lmask = (n_ff == 4'h1) ? 8'hFF : (n_ff == 4'h2) ? 8'h0F
		: (n_ff == 4'h4) ? 8'h03 : 8'h01;

	// edge count restarts with every frame; select high clears it at once
	always_ff @(posedge sclk or posedge ss_n) begin
		if (ss_n) begin
			cnt_ff <= 5'h00;
		end else begin
			if (cnt_ff != 5'h1F) begin
				cnt_ff <= cnt_ff + 5'h01;
			end
			if (cnt_ff == 5'h00) begin
				cmd_ff <= bidir_data_lanes;
				n_ff <= n_dec;
			end
		end
	end

	////////////////////////////////////////
	idle_status_a: assert property (@(posedge i_clk) disable iff (i_rst)
		ss_n && i_status_en |-> s_lane_oe[0] && s_miso_oe) else $error("idle status not driven");
	quiet_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
		ss_n && !i_status_en |-> s_lane_oe == 8'h00 && !s_miso_oe) else $error("idle drive when off");
	release_lane_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(ss_n) |-> (s_lane_oe == 8'h00) [*3]) else $error("lanes held after select");
	read_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(ss_n) && i_status_en |-> s_lane_oe == 8'h01) else $error("bad drive after deselect");
	cmd_quiet_a: assert property (@(posedge sclk) disable iff (i_rst || ss_n)
		cnt_ff == 5'h00 || cnt_ff < {1'h0, n_ff} |-> s_lane_oe == 8'h00)
		else $error("device drove lanes in command phase");
	lane_mask_a: assert property (@(posedge sclk) disable iff (i_rst || ss_n)
		cnt_ff != 5'h00 |-> (s_lane_oe & ~lmask) == 8'h00) else $error("lane beyond width driven");
	ack_valid_a: assert property (@(posedge sclk) disable iff (i_rst || ss_n)
		cnt_ff != 5'h00 && cnt_ff >= {1'h0, n_ff} |-> s_miso_oe) else $error("no ack in data phase");
	ack_hold_a: assert property (@(posedge sclk) disable iff (i_rst || ss_n)
		cnt_ff > {1'h0, n_ff} && cnt_ff < {n_ff, 1'h0} |-> $stable(s_miso_o))
		else $error("ack changed in data phase");
	bad_cmd_nak_a: assert property (@(posedge sclk) disable iff (i_rst || ss_n)
		cnt_ff == 5'h01 && n_ff == 4'h1 && {cmd_ff[0], cmd_ff[3], cmd_ff[5], cmd_ff[6]} > 4'h1
		|-> s_miso_o == 1'h0) else $error("unknown command not refused");
endmodule

// File: tb/test_variable_width_slave_link.sv
// self-checking bench: controller and device ends joined by the link
// assumes the controller makes the link clock from i_clk
`timescale 1ns/1ns
module test_variable_width_slave_link;
	logic i_clk;
	logic i_rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic status_en;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ready;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;

	vw_link_if lk();
	vw_ctl_end #(.DIV(2)) i_vw_ctl_end (.lk(lk), .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
	vw_dev_end i_vw_dev_end (.lk(lk), .i_clk(i_clk), .i_rst(i_rst), .i_status_en(status_en),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready));
	vw_link_checker i_vw_link_checker (.i_clk(i_clk), .i_rst(i_rst), .i_status_en(status_en),
		.ss_n(lk.ss_n), .sclk(lk.sclk), .s_lane_oe(lk.s_lane_oe), .s_miso_o(lk.s_miso_o),
		.s_miso_oe(lk.s_miso_oe), .bidir_data_lanes(lk.bidir_data_lanes));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_stat(output logic [31:0] st);
		logic e;
		apb(1'b0, vw_pkg::REG_STAT, 32'h0, st, e);
	endtask

	// one frame, then poll until the controller is idle again
	task automatic frame(input logic [3:0] c, input logic [1:0] w, input logic [7:0] b,
			output logic [31:0] st);
		logic e;
		apb(1'b1, vw_pkg::REG_CTRL, {1'b1, 15'h0000, b, 2'h0, w, c}, st, e);
		do rd_stat(st); while (st[vw_pkg::STAT_BUSY] !== 1'b0);
	endtask

	// link clock stands still between frames, so the device's buffer-state
	// synchronisers lag; a refused 1-lane frame lets them catch up before a
	// 4- or 8-lane frame, which decides after only one or two edges
	task automatic sync_frame();
		logic [31:0] st;
		frame(4'h2, vw_pkg::W1, 8'h00, st);
		check(st[vw_pkg::STAT_NAK], 1'b1);
	endtask

	task automatic wait_rx(input logic [7:0] exp);
		int k;
		k = 0;
		while (rx_valid !== 1'b1 && k < 40) begin
			@(negedge i_clk);
			k++;
		end
		check(rx_valid, 1'b1);
		check(rx_data, exp);
		@(posedge i_clk);
		rx_ready <= 1'b1;
		@(posedge i_clk);
		rx_ready <= 1'b0;
	endtask

	////////////////////////////////////////
	task automatic t_idle();
		logic [31:0] q;
		logic e;
		repeat (4) @(posedge i_clk);
		rd_stat(q);
		check(q[3:0], 4'h4);
		apb(1'b0, 8'h08, 32'h0, q, e);
		check(e, 1'b1);
		status_en <= 1'b0;
		repeat (4) @(posedge i_clk);
		rd_stat(q);
		// nobody drives, so both status wires float up
		check(q[3:2], 2'h3);
		status_en <= 1'b1;
	endtask

	task automatic t_write();
		logic [31:0] st;
		for (int w = 0; w < 4; w++) begin
			if (w > 1) begin
				sync_frame();
			end
			frame(vw_pkg::CMD_WRITE, 2'(w), 8'h3C ^ 8'(w * 17), st);
			check(st[vw_pkg::STAT_NAK], 1'b0);
			wait_rx(8'h3C ^ 8'(w * 17));
		end
		frame(vw_pkg::CMD_WRITE, vw_pkg::W1, 8'h81, st);
		frame(vw_pkg::CMD_WRITE, vw_pkg::W1, 8'h42, st);
		check(st[vw_pkg::STAT_NAK], 1'b1);
		repeat (4) @(posedge i_clk);
		rd_stat(st);
		check(st[vw_pkg::STAT_WRF], 1'b0);
		wait_rx(8'h81);
	endtask

	task automatic t_read();
		logic [31:0] st;
		for (int w = 0; w < 4; w++) begin
			@(posedge i_clk);
			tx_data <= 8'hC3 ^ 8'(w * 5);
			tx_valid <= 1'b1;
			forever begin
				@(negedge i_clk);
				if (tx_ready === 1'b1) break;
			end
			@(posedge i_clk);
			tx_valid <= 1'b0;
			repeat (8) @(posedge i_clk);
			if (w > 1) begin
				sync_frame();
			end
			frame(vw_pkg::CMD_READ, 2'(w), 8'h00, st);
			check(st[vw_pkg::STAT_NAK], 1'b0);
			check(st[15:8], 8'hC3 ^ 8'(w * 5));
		end
		frame(vw_pkg::CMD_READ, vw_pkg::W8, 8'h00, st);
		check(st[vw_pkg::STAT_NAK], 1'b1);
	endtask

	task automatic t_cmds();
		logic [31:0] st;
		for (int c = 2; c < 16; c++) begin
			frame(4'(c), 2'(c), 8'h00, st);
			check(st[vw_pkg::STAT_NAK], 1'b1);
		end
	endtask

	////////////////////////////////////////
	initial begin
		i_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		status_en = 1'b1;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		t_idle();
		t_write();
		t_read();
		t_cmds();
		tally_and_finish();
	end

	// whole run is about a thousand cycles; this only cuts a hang short
	initial begin
		forever begin
			@(posedge i_clk);
			cyc++;
			if (cyc == 30000) begin
				n_mismatch++;
				tally_and_finish();
			end
		end
	end
endmodule
